// [shared/cmspb_params.svh]
// Offsets, field positions and reset values of the clock status block
// Notes on behaviour
// - Bit 0 of clock status shows whether the processor clock runs.
// - Bit 6 of clock status shows the USB host clock enable.
// - Bit 7 of clock status shows the USB device clock enable.
// - Bits 8 to 11 show each programmable clock output enable.
// - Input divider: 0 gives no output, 1 bypasses, 2-255 divide.
// - After a config write, count programmed slow cycles, then set lock.
// - Multiplier 0 stops the PLL; otherwise output is input times value+1.
// - USB divider: 00 passes, 01 halves, 10 quarters, 11 reserved.
// - Status bit 0 shows the main oscillator is stable.
// - Status bits 1 and 2 show first and second PLL lock.
// - Status bit 3 shows the master clock is ready.
// - Status bit 7 shows slow clock source: 0 RC, 1 crystal.
// - Status bits 8 to 11 show each programmable clock ready.
`ifndef CMSPB_PARAMS_SVH
`define CMSPB_PARAMS_SVH

`define CMSPB_OFS_SCSR       8'h00
`define CMSPB_OFS_PLLB       8'h04
`define CMSPB_OFS_SR         8'h08
`define CMSPB_OFS_INT_STAT   8'h0C
`define CMSPB_OFS_INT_MASK   8'h10

`define CMSPB_PLLB_DIV_LSB   0
`define CMSPB_PLLB_DIV_MSB   7
`define CMSPB_PLLB_CNT_LSB   8
`define CMSPB_PLLB_CNT_MSB   13
`define CMSPB_PLLB_OUT_LSB   14
`define CMSPB_PLLB_OUT_MSB   15
`define CMSPB_PLLB_MUL_LSB   16
`define CMSPB_PLLB_MUL_MSB   26
`define CMSPB_PLLB_USB_LSB   28
`define CMSPB_PLLB_USB_MSB   29

`define CMSPB_PLLB_RESET     32'h00000000
`define CMSPB_INT_MASK_RESET 32'h00000000
`define CMSPB_SR_VALID       32'h00000F8F

`define CMSPB_USB_DIV1       2'h0
`define CMSPB_USB_DIV2       2'h1
`define CMSPB_USB_DIV4       2'h2

`define CMSPB_SYNC_WIDTH     16

`endif

// [shared/cmspb_pkg.sv]
// Types shared by the clock status block
package cmspb_pkg;

  typedef logic [31:0] cmspb_word_t;
  typedef logic [7:0]  cmspb_addr_t;

  typedef enum logic [1:0] {
    CMSPB_LOCK_IDLE,
    CMSPB_LOCK_COUNT,
    CMSPB_LOCK_DONE
  } cmspb_lock_state_t;

endpackage : cmspb_pkg

// [sim/cmspb_checker.sv]
// Assertions on the APB and second PLL ports of the clock status block
`timescale 1ns/100ps
`include "cmspb_params.svh"
module cmspb_checker (
  input wire logic                   clk_sys,
  input wire logic                   resetn,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire cmspb_pkg::cmspb_addr_t paddr,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire logic [7:0]             second_pll_input_divider,
  input wire logic [10:0]            second_pll_multiplier,
  input wire logic [1:0]             usb_clock_divider,
  input wire logic                   second_pll_active,
  input wire logic [11:0]            second_pll_mult_factor,
  input wire logic                   second_pll_ref_gated,
  input wire logic                   second_pll_ref_bypass,
  input wire logic [1:0]             usb_clock_div_shift,
  input wire logic                   usb_clock_div_reserved,
  input wire logic                   second_pll_locked
);
  import cmspb_pkg::*;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  sequence s_access;
    psel && penable && pready;
  endsequence
  sequence s_cfg_write;
    s_access ##0 (pwrite && paddr == `CMSPB_OFS_PLLB);
  endsequence
  a_setup_answer: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_unmapped: assert property (s_access |-> pslverr == !(paddr inside
    {`CMSPB_OFS_SCSR, `CMSPB_OFS_PLLB, `CMSPB_OFS_SR, `CMSPB_OFS_INT_STAT,
     `CMSPB_OFS_INT_MASK})) else $error("error flag wrong for address");
  a_ref_gated: assert property (
    second_pll_ref_gated == (second_pll_input_divider == 8'h00))
    else $error("divider gate wrong");
  a_ref_bypass: assert property (
    second_pll_ref_bypass == (second_pll_input_divider == 8'h01))
    else $error("divider bypass wrong");
  a_mul_active: assert property (
    second_pll_active == (second_pll_multiplier != 11'h000))
    else $error("pll active wrong");
  a_mul_factor: assert property (second_pll_active |->
    second_pll_mult_factor == {1'b0, second_pll_multiplier} + 12'h001)
    else $error("multiplier factor wrong");
  a_usb_shift: assert property (
    usb_clock_div_shift == (usb_clock_divider == 2'h3 ? 2'h0 :
    usb_clock_divider) && usb_clock_div_reserved == (usb_clock_divider ==
    2'h3)) else $error("usb divider decode wrong");
  a_lock_clear: assert property (s_cfg_write |=>
    !second_pll_locked) else $error("lock not cleared by write");
  a_lock_needs_mul: assert property ($rose(second_pll_locked) |->
    second_pll_active) else $error("lock with pll stopped");
endmodule : cmspb_checker

bind cmspb_top cmspb_checker cmspb_checker_inst (
  .clk_sys, .resetn, .psel, .penable, .pwrite, .paddr, .pready, .pslverr,
  .second_pll_input_divider, .second_pll_multiplier, .usb_clock_divider,
  .second_pll_active, .second_pll_mult_factor, .second_pll_ref_gated,
  .second_pll_ref_bypass, .usb_clock_div_shift, .usb_clock_div_reserved,
  .second_pll_locked
);

// [sim/tb.sv]
// Self-checking bench for the clock status block
`timescale 1ns/100ps
`include "cmspb_params.svh"
module tb;
  import cmspb_pkg::*;
  typedef struct {cmspb_word_t d; cmspb_word_t m; logic e;} cmspb_exp_t;
  logic        clk_sys, resetn, psel, penable, pwrite, pready, pslverr;
  cmspb_addr_t paddr;
  cmspb_word_t pwdata, prdata;
  logic        processor_clock_on, usb_host_clock_on, usb_device_clock_on;
  logic        main_osc_stable, first_pll_locked, master_clock_ready;
  logic        slow_clock_source, slow_clk;
  logic [3:0]  prog_clock_output_on, prog_clock_ready;
  logic [7:0]  second_pll_input_divider;
  logic [5:0]  second_pll_lock_count;
  logic [1:0]  second_pll_freq_range, usb_clock_divider, usb_clock_div_shift;
  logic [10:0] second_pll_multiplier;
  logic [11:0] second_pll_mult_factor;
  logic        second_pll_active, second_pll_ref_gated, second_pll_ref_bypass;
  logic        usb_clock_div_reserved, second_pll_locked, irq;
  cmspb_exp_t  exq[$];
  int          failures, n_tests, cyc;

  cmspb_top cmspb_top_inst (
    .clk_sys, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .processor_clock_on, .usb_host_clock_on,
    .usb_device_clock_on, .prog_clock_output_on, .main_osc_stable,
    .first_pll_locked, .master_clock_ready, .slow_clock_source,
    .prog_clock_ready, .slow_clk, .second_pll_input_divider,
    .second_pll_lock_count, .second_pll_freq_range, .second_pll_multiplier,
    .usb_clock_divider, .second_pll_active, .second_pll_mult_factor,
    .second_pll_ref_gated, .second_pll_ref_bypass, .usb_clock_div_shift,
    .usb_clock_div_reserved, .second_pll_locked, .irq
  );

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic end_of_test();
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  task automatic bad(string s);
    failures++;
    $display("mismatch at %0t: %s", $time, s);
  endtask : bad

  task automatic cmp_out(cmspb_word_t got, cmspb_word_t exp);
    n_tests++;
    if (got !== exp)
      bad($sformatf("output %h expected %h", got, exp));
  endtask : cmp_out

  // Read data are judged by the watcher at the edge pready is sampled
  task automatic apb(logic w, cmspb_addr_t a, cmspb_word_t d,
                     cmspb_word_t m, cmspb_word_t x, logic er);
    exq.push_back('{x, m, er});
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // Only pready or the bench timeout ends this wait
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic pins(cmspb_word_t v);
    processor_clock_on   <= v[0];
    usb_host_clock_on    <= v[6];
    usb_device_clock_on  <= v[7];
    prog_clock_output_on <= v[11:8];
    main_osc_stable      <= v[0];
    first_pll_locked     <= v[1];
    master_clock_ready   <= v[3];
    slow_clock_source    <= v[7];
    prog_clock_ready     <= v[11:8];
  endtask : pins

  // Slow period of 8 system cycles keeps within the sampler's reach
  task automatic slow(int k);
    repeat (k) begin
      repeat (4) @(posedge clk_sys);
      slow_clk <= 1'b1;
      repeat (4) @(posedge clk_sys);
      slow_clk <= 1'b0;
    end
  endtask : slow

  always @(posedge clk_sys) begin
    if (psel && penable && pready === 1'b1) begin
      cmspb_exp_t x;
      x = exq.pop_front();
      n_tests++;
      if ((prdata & x.m) !== x.d || pslverr !== x.e)
        bad($sformatf("read %h err %b expected %h", prdata, pslverr, x.d));
    end
  end

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 6000) begin
      failures++;
      end_of_test();
    end
  end

  initial begin
    cmspb_word_t v, e;
    int          i;
    {psel, penable, pwrite, slow_clk, resetn} <= '0;
    paddr  <= '0;
    pwdata <= '0;
    pins('0);
    void'($urandom(32'hB278));
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    apb(0, `CMSPB_OFS_PLLB, $urandom, '1, `CMSPB_PLLB_RESET, 0);
    apb(0, `CMSPB_OFS_INT_MASK, $urandom, '1, `CMSPB_INT_MASK_RESET, 0);
    apb(0, 8'h14, $urandom, '1, 32'h00000000, 1);
    cmp_out(second_pll_ref_gated, 1);
    for (i = 0; i < 6; i++) begin
      v = $urandom;
      pins(v);
      repeat (4) @(posedge clk_sys);
      apb(1, `CMSPB_OFS_SCSR, ~v, 0, 0, 0);
      apb(1, `CMSPB_OFS_SR, ~v, 0, 0, 0);
      apb(0, `CMSPB_OFS_SCSR, v, '1, v & 32'h00000FC1, 0);
      apb(0, `CMSPB_OFS_SR, v, '1, v & 32'h00000F8B, 0);
    end
    pins('0);
    repeat (4) @(posedge clk_sys);
    apb(1, `CMSPB_OFS_INT_STAT, '1, 0, 0, 0);
    apb(1, `CMSPB_OFS_INT_MASK, '1, 0, 0, 0);
    apb(0, `CMSPB_OFS_INT_MASK, 0, '1, `CMSPB_SR_VALID, 0);
    cmp_out(irq, 0);
    pins(32'h00000001);
    repeat (6) @(posedge clk_sys);
    cmp_out(irq, 1);
    apb(0, `CMSPB_OFS_INT_STAT, 0, '1, 32'h00000001, 0);
    apb(1, `CMSPB_OFS_INT_STAT, 32'h00000001, 0, 0, 0);
    repeat (3) @(posedge clk_sys);
    cmp_out(irq, 0);
    apb(1, `CMSPB_OFS_INT_MASK, 0, 0, 0, 0);
    pins(32'h00000009);
    repeat (6) @(posedge clk_sys);
    cmp_out(irq, 0);
    apb(0, `CMSPB_OFS_INT_STAT, 0, '1, 32'h00000008, 0);
    // Edge values of the divider and multiplier, every usb code
    for (i = 0; i < 8; i++) begin
      v = $urandom & 32'h37FFFFFF;
      v[7:0] = i == 0 ? 8'h00 : i == 1 ? 8'h01 : i == 2 ? 8'h02 : 8'hFF;
      v[26:16] = i == 4 ? 11'h000 : i == 5 ? 11'h001 : i == 6 ? 11'h7FF :
                 v[26:16];
      v[29:28] = i[1:0];
      apb(1, `CMSPB_OFS_PLLB, v, 0, 0, 0);
      apb(0, `CMSPB_OFS_PLLB, 0, 32'h37FFFFFF, v, 0);
      e = {14'h0000, v[7:0] == 8'h00, v[7:0] == 8'h01, v[26:16] != 11'h000,
           v[29:28] == 2'h3, (v[29:28] == 2'h3 ? 2'h0 : v[29:28]),
           {1'b0, v[26:16]} + 12'h001};
      cmp_out({14'h0000, second_pll_ref_gated, second_pll_ref_bypass,
               second_pll_active, usb_clock_div_reserved,
               usb_clock_div_shift, second_pll_mult_factor}, e);
      cmp_out({3'h0, usb_clock_divider, second_pll_freq_range,
               second_pll_multiplier, second_pll_lock_count,
               second_pll_input_divider}, {3'h0, v[29:28], v[15:14],
               v[26:16], v[13:8], v[7:0]});
    end
    apb(1, `CMSPB_OFS_PLLB, 32'h00010300, 0, 0, 0);
    repeat (2) @(posedge clk_sys);
    cmp_out(second_pll_locked, 0);
    slow(2);
    repeat (8) @(posedge clk_sys);
    cmp_out(second_pll_locked, 0);
    slow(1);
    i = 0;
    while (second_pll_locked !== 1'b1 && i < 20) begin
      @(posedge clk_sys);
      i++;
    end
    cmp_out(second_pll_locked, 1);
    apb(0, `CMSPB_OFS_SR, 0, 32'h00000004, 32'h00000004, 0);
    // Rewrite while locked: count must restart from the new value
    apb(1, `CMSPB_OFS_PLLB, 32'h00010200, 0, 0, 0);
    repeat (2) @(posedge clk_sys);
    cmp_out(second_pll_locked, 0);
    slow(1);
    repeat (8) @(posedge clk_sys);
    cmp_out(second_pll_locked, 0);
    slow(1);
    repeat (4) @(posedge clk_sys);
    cmp_out(second_pll_locked, 1);
    apb(1, `CMSPB_OFS_PLLB, 32'h00000101, 0, 0, 0);
    repeat (2) @(posedge clk_sys);
    cmp_out(second_pll_locked, 0);
    slow(3);
    repeat (8) @(posedge clk_sys);
    cmp_out(second_pll_locked, 0);
    end_of_test();
  end
endmodule : tb

// [src/cmspb_lock_ctr.sv]
// Slow-clock lock counter for the second PLL
`timescale 1ns/100ps
module cmspb_lock_ctr #(
  parameter int CW = 6
) (
  input  wire logic          clk_sys,
  input  wire logic          resetn,
  input  wire logic          restart,
  input  wire logic [CW-1:0] count_val,
  input  wire logic          active,
  input  wire logic          slow_tick,
  output logic               locked
);
  import cmspb_pkg::*;

  cmspb_lock_state_t state_r;
  logic [CW-1:0]     cnt_r;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_r <= CMSPB_LOCK_IDLE;
      cnt_r   <= '0;
      locked  <= 1'b0;
    end else if (restart) begin
      // New write drops lock at once and reloads
      state_r <= CMSPB_LOCK_COUNT;
      cnt_r   <= count_val;
      locked  <= 1'b0;
    end else begin
      case (state_r)
        CMSPB_LOCK_IDLE: begin
          locked <= 1'b0;
        end
        CMSPB_LOCK_COUNT: begin
          // Stopped PLL never locks
          if (!active) begin
            state_r <= CMSPB_LOCK_IDLE;
          end else if (cnt_r == '0) begin
            state_r <= CMSPB_LOCK_DONE;
            locked  <= 1'b1;
          end else if (slow_tick) begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        CMSPB_LOCK_DONE: begin
          locked <= 1'b1;
        end
        default: begin
          state_r <= CMSPB_LOCK_IDLE;
          locked  <= 1'b0;
        end
      endcase
    end
  end

endmodule : cmspb_lock_ctr

// [src/cmspb_sync.sv]
// Two-stage synchroniser for a group of pin levels
`timescale 1ns/100ps
module cmspb_sync #(
  parameter int WIDTH = 16
) (
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      logic meta_r;
      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          meta_r      <= 1'b0;
          sync_out[gi] <= 1'b0;
        end else begin
          meta_r      <= async_in[gi];
          sync_out[gi] <= meta_r;
        end
      end
    end
  endgenerate

endmodule : cmspb_sync

// [src/cmspb_top.sv]
// Clock status, second PLL configuration and status interrupts over APB
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "cmspb_params.svh"
module cmspb_top (
  input  wire logic               clk_sys,
  input  wire logic               resetn,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire cmspb_pkg::cmspb_addr_t paddr,
  input  wire cmspb_pkg::cmspb_word_t pwdata,
  output cmspb_pkg::cmspb_word_t  prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Clock tree state, asynchronous to clk_sys
  input  wire logic               processor_clock_on,
  input  wire logic               usb_host_clock_on,
  input  wire logic               usb_device_clock_on,
  input  wire logic [3:0]         prog_clock_output_on,
  input  wire logic               main_osc_stable,
  input  wire logic               first_pll_locked,
  input  wire logic               master_clock_ready,
  input  wire logic               slow_clock_source,
  input  wire logic [3:0]         prog_clock_ready,
  input  wire logic               slow_clk,
  // Second PLL control
  output logic [7:0]              second_pll_input_divider,
  output logic [5:0]              second_pll_lock_count,
  output logic [1:0]              second_pll_freq_range,
  output logic [10:0]             second_pll_multiplier,
  output logic [1:0]              usb_clock_divider,
  output logic                    second_pll_active,
  output logic [11:0]             second_pll_mult_factor,
  output logic                    second_pll_ref_gated,
  output logic                    second_pll_ref_bypass,
  output logic [1:0]              usb_clock_div_shift,
  output logic                    usb_clock_div_reserved,
  output logic                    second_pll_locked,
  // Interrupt
  output logic                    irq
);
  import cmspb_pkg::*;

  // Synchronised pin levels
  logic [`CMSPB_SYNC_WIDTH-1:0] pins_async;
  logic [`CMSPB_SYNC_WIDTH-1:0] pins_sync;
  logic                         s_cpu_on;
  logic                         s_host_on;
  logic                         s_dev_on;
  logic [3:0]                   s_prog_on;
  logic                         s_mosc;
  logic                         s_first_lock;
  logic                         s_mck;
  logic                         s_slow_src;
  logic [3:0]                   s_prog_rdy;
  logic                         s_slow;

  // Bus decode
  logic        setup_phase;
  logic        access_wr;
  logic        hit_scsr;
  logic        hit_pllb;
  logic        hit_sr;
  logic        hit_int_stat;
  logic        hit_int_mask;
  logic        hit_any;
  logic        pllb_wr;

  // Register state
  cmspb_word_t pllb_r;
  cmspb_word_t int_stat_r;
  cmspb_word_t int_stat_nxt;
  cmspb_word_t int_mask_r;
  cmspb_word_t sr_prev_r;
  cmspb_word_t rd_nxt;
  cmspb_word_t scsr_word;
  cmspb_word_t sr_word;
  cmspb_word_t events;
  cmspb_word_t int_clr;
  logic        slow_prev_r;
  logic        slow_tick;
  logic        second_lock;

  // One synchroniser for all pin levels; the slow clock rides along
  assign pins_async = {slow_clk, prog_clock_ready, slow_clock_source,
                       master_clock_ready, first_pll_locked,
                       main_osc_stable, prog_clock_output_on,
                       usb_device_clock_on, usb_host_clock_on,
                       processor_clock_on};

  cmspb_sync #(
    .WIDTH (`CMSPB_SYNC_WIDTH)
  ) u_sync (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .async_in (pins_async),
    .sync_out (pins_sync)
  );

  // Bit positions follow the packing order above
  assign s_cpu_on     = pins_sync[0];
  assign s_host_on    = pins_sync[1];
  assign s_dev_on     = pins_sync[2];
  assign s_prog_on    = pins_sync[6:3];
  assign s_mosc       = pins_sync[7];
  assign s_first_lock = pins_sync[8];
  assign s_mck        = pins_sync[9];
  assign s_slow_src   = pins_sync[10];
  assign s_prog_rdy   = pins_sync[14:11];
  assign s_slow       = pins_sync[15];

  // Slow clock rising edge; sampled, so it must be well below clk_sys
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      slow_prev_r <= 1'b0;
    end else begin
      slow_prev_r <= s_slow;
    end
  end

  assign slow_tick = s_slow & ~slow_prev_r;

  // Status words; unlisted bits stay zero
  assign scsr_word = {20'h00000, s_prog_on, s_dev_on, s_host_on, 5'h00,
                      s_cpu_on};
  assign sr_word   = {20'h00000, s_prog_rdy, s_slow_src, 3'h0,
                      s_mck, second_lock, s_first_lock,
                      s_mosc};

  // APB decode
  // Full byte compare; unaligned offsets answer with an error
  assign setup_phase  = psel & ~penable;
  assign access_wr    = psel & penable & pready & pwrite;
  assign hit_scsr     = (paddr == `CMSPB_OFS_SCSR);
  assign hit_pllb     = (paddr == `CMSPB_OFS_PLLB);
  assign hit_sr       = (paddr == `CMSPB_OFS_SR);
  assign hit_int_stat = (paddr == `CMSPB_OFS_INT_STAT);
  assign hit_int_mask = (paddr == `CMSPB_OFS_INT_MASK);
  assign hit_any      = hit_scsr | hit_pllb | hit_sr | hit_int_stat |
                        hit_int_mask;
  assign pllb_wr      = access_wr & hit_pllb;

  // One wait-free access phase: ready is raised by the setup edge
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup_phase & ~pready;
    end
  end

  // Read-only words take writes silently; only unmapped ones err
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      pslverr <= ~hit_any;
    end else begin
      pslverr <= 1'b0;
    end
  end

  always_comb begin
    rd_nxt = 32'h00000000;
    if (hit_scsr) begin
      rd_nxt = scsr_word;
    end else if (hit_pllb) begin
      rd_nxt = pllb_r;
    end else if (hit_sr) begin
      rd_nxt = sr_word;
    end else if (hit_int_stat) begin
      rd_nxt = int_stat_r;
    end else if (hit_int_mask) begin
      rd_nxt = int_mask_r;
    end
  end

  // Read data captured at the setup edge, held through the access
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h00000000;
    end else if (setup_phase && !pwrite) begin
      prdata <= rd_nxt;
    end else if (!psel) begin
      prdata <= 32'h00000000;
    end
  end

  // Configuration register; only mapped fields are stored
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pllb_r <= `CMSPB_PLLB_RESET;
    end else if (pllb_wr) begin
      pllb_r <= 32'h00000000;
      pllb_r[`CMSPB_PLLB_DIV_MSB:`CMSPB_PLLB_DIV_LSB] <=
        pwdata[`CMSPB_PLLB_DIV_MSB:`CMSPB_PLLB_DIV_LSB];
      pllb_r[`CMSPB_PLLB_CNT_MSB:`CMSPB_PLLB_CNT_LSB] <=
        pwdata[`CMSPB_PLLB_CNT_MSB:`CMSPB_PLLB_CNT_LSB];
      pllb_r[`CMSPB_PLLB_OUT_MSB:`CMSPB_PLLB_OUT_LSB] <=
        pwdata[`CMSPB_PLLB_OUT_MSB:`CMSPB_PLLB_OUT_LSB];
      pllb_r[`CMSPB_PLLB_MUL_MSB:`CMSPB_PLLB_MUL_LSB] <=
        pwdata[`CMSPB_PLLB_MUL_MSB:`CMSPB_PLLB_MUL_LSB];
      pllb_r[`CMSPB_PLLB_USB_MSB:`CMSPB_PLLB_USB_LSB] <=
        pwdata[`CMSPB_PLLB_USB_MSB:`CMSPB_PLLB_USB_LSB];
    end
  end

  // Raw fields to the analog PLL, updated with the register
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      second_pll_input_divider <= 8'h00;
      second_pll_lock_count    <= 6'h00;
      second_pll_freq_range    <= 2'h0;
      second_pll_multiplier    <= 11'h000;
      usb_clock_divider        <= 2'h0;
    end else if (pllb_wr) begin
      second_pll_input_divider <=
        pwdata[`CMSPB_PLLB_DIV_MSB:`CMSPB_PLLB_DIV_LSB];
      second_pll_lock_count    <=
        pwdata[`CMSPB_PLLB_CNT_MSB:`CMSPB_PLLB_CNT_LSB];
      second_pll_freq_range    <=
        pwdata[`CMSPB_PLLB_OUT_MSB:`CMSPB_PLLB_OUT_LSB];
      second_pll_multiplier    <=
        pwdata[`CMSPB_PLLB_MUL_MSB:`CMSPB_PLLB_MUL_LSB];
      usb_clock_divider        <=
        pwdata[`CMSPB_PLLB_USB_MSB:`CMSPB_PLLB_USB_LSB];
    end
  end

  // Decoded input divider mode
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      second_pll_ref_gated  <= 1'b1;
      second_pll_ref_bypass <= 1'b0;
    end else if (pllb_wr) begin
      second_pll_ref_gated  <=
        (pwdata[`CMSPB_PLLB_DIV_MSB:`CMSPB_PLLB_DIV_LSB] == 8'h00);
      second_pll_ref_bypass <=
        (pwdata[`CMSPB_PLLB_DIV_MSB:`CMSPB_PLLB_DIV_LSB] == 8'h01);
    end
  end

  // Multiplier: zero stops the PLL, else factor is value plus one
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      second_pll_active      <= 1'b0;
      second_pll_mult_factor <= 12'h000;
    end else if (pllb_wr) begin
      second_pll_active      <=
        (pwdata[`CMSPB_PLLB_MUL_MSB:`CMSPB_PLLB_MUL_LSB] != 11'h000);
      second_pll_mult_factor <=
        {1'b0, pwdata[`CMSPB_PLLB_MUL_MSB:`CMSPB_PLLB_MUL_LSB]}
        + 12'h001;
    end
  end

  // USB divider as a shift count; reserved code falls back to pass
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      usb_clock_div_shift    <= 2'h0;
      usb_clock_div_reserved <= 1'b0;
    end else if (pllb_wr) begin
      case (pwdata[`CMSPB_PLLB_USB_MSB:`CMSPB_PLLB_USB_LSB])
        `CMSPB_USB_DIV1: begin
          usb_clock_div_shift    <= 2'h0;
          usb_clock_div_reserved <= 1'b0;
        end
        `CMSPB_USB_DIV2: begin
          usb_clock_div_shift    <= 2'h1;
          usb_clock_div_reserved <= 1'b0;
        end
        `CMSPB_USB_DIV4: begin
          usb_clock_div_shift    <= 2'h2;
          usb_clock_div_reserved <= 1'b0;
        end
        default: begin
          usb_clock_div_shift    <= 2'h0;
          usb_clock_div_reserved <= 1'b1;
        end
      endcase
    end
  end

  // Count comes from the bus word so the reload lands on the write
  // edge itself, not one cycle later from the stored copy
  cmspb_lock_ctr #(
    .CW (6)
  ) u_lock (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .restart   (pllb_wr),
    .count_val (pwdata[`CMSPB_PLLB_CNT_MSB:`CMSPB_PLLB_CNT_LSB]),
    .active    (second_pll_active),
    .slow_tick (slow_tick),
    .locked    (second_lock)
  );

  assign second_pll_locked = second_lock;

  // Rising status bits are the interrupt events
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sr_prev_r <= 32'h00000000;
    end else begin
      sr_prev_r <= sr_word;
    end
  end

  assign events  = sr_word & ~sr_prev_r & `CMSPB_SR_VALID;
  assign int_clr = (access_wr && hit_int_stat) ? pwdata : 32'h00000000;

  // Write one to clear; a same-cycle event wins
  always_comb begin
    int_stat_nxt = (int_stat_r & ~int_clr) | events;
  end

  // Sticky until software writes a one back
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      int_stat_r <= 32'h00000000;
    end else begin
      int_stat_r <= int_stat_nxt;
    end
  end

  // Unmapped bits held at zero so they can never raise the line
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      int_mask_r <= `CMSPB_INT_MASK_RESET;
    end else if (access_wr && hit_int_mask) begin
      int_mask_r <= pwdata & `CMSPB_SR_VALID;
    end
  end

  // Built from the next status so the line rises with the bit
  // A mask write takes effect one edge after it lands
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_stat_nxt & int_mask_r);
    end
  end

endmodule : cmspb_top
